//--- pbs_button_timer.v
// Debounces the power switch and measures each press length.
// Assumes the switch input is already synchronised to i_core_clk.
`timescale 1ns/10ps
`include "pbs_consts.vh"
module pbs_button_timer #(
  parameter DEB_CYC  = `PBS_DEB_CYC,
  parameter LONG_CYC = `PBS_LONG_CYC
) (
  // Clock and reset
  input  wire i_core_clk,
  input  wire i_rst,
  // Synchronised switch level
  input  wire i_sw_sync,
  // Press results, one-cycle pulses at release or at threshold
  output reg  o_short_press,
  output reg  o_long_press
);
  reg [19:0] deb_cnt_q;
  reg        sw_deb_q;
  reg [27:0] hold_cnt_q;
  reg        long_done_q;

  // RULE13 debounce filter
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      deb_cnt_q <= 20'h00000;
      sw_deb_q  <= 1'b0;
    end else if (i_sw_sync == sw_deb_q) begin
      deb_cnt_q <= 20'h00000;
    end else if (deb_cnt_q == DEB_CYC[19:0] - 20'h00001) begin
      deb_cnt_q <= 20'h00000;
      sw_deb_q  <= i_sw_sync;
    end else begin
      deb_cnt_q <= deb_cnt_q + 20'h00001;
    end
  end

  // RULE13 press timer, exactly four seconds counts as long
  // Long press fires while still held so a stuck switch still powers off
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      hold_cnt_q    <= 28'h0000000;
      long_done_q   <= 1'b0;
      o_short_press <= 1'b0;
      o_long_press  <= 1'b0;
    end else begin
      o_short_press <= 1'b0;
      o_long_press  <= 1'b0;
      if (sw_deb_q) begin
        if (!long_done_q) begin
          if (hold_cnt_q == LONG_CYC[27:0] - 28'h0000001) begin
            long_done_q  <= 1'b1;
            o_long_press <= 1'b1;
          end else begin
            hold_cnt_q <= hold_cnt_q + 28'h0000001;
          end
        end
      end else begin
        if (!long_done_q && hold_cnt_q != 28'h0000000) begin
          o_short_press <= 1'b1;
        end
        hold_cnt_q  <= 28'h0000000;
        long_done_q <= 1'b0;
      end
    end
  end
endmodule // pbs_button_timer

//--- pbs_consts.vh
// Constants for the power button sleep sequencer.
// Assumes a 25 MHz standby clock; included by bare name.
`ifndef PBS_CONSTS_VH
`define PBS_CONSTS_VH
`define PBS_CLK_HZ        25000000
`define PBS_LONG_PRESS_MS 4000
`define PBS_DEBOUNCE_US   10000
`define PBS_LONG_CYC      ((`PBS_CLK_HZ / 1000) * `PBS_LONG_PRESS_MS)
`define PBS_DEB_CYC       ((`PBS_CLK_HZ / 1000000) * `PBS_DEBOUNCE_US)
`define PBS_ST_S0         3'h0
`define PBS_ST_S1         3'h1
`define PBS_ST_S3         3'h3
`define PBS_ST_S4         3'h4
`define PBS_ST_S5         3'h5
`define PBS_AFL_OFF       2'h0
`define PBS_AFL_ON        2'h1
`define PBS_AFL_LAST      2'h2
`endif

//--- pbs_far_side.sv
// Far side model: power switch, mains supply, wake sources.
// Assumes pins change one small delay after a clock edge.
`timescale 1ns/10ps
module pbs_far_side #(
  parameter DEB_CYC = 4
) (
  input  wire       i_core_clk,
  output reg        o_pwr_sw,
  output reg        o_ac_ok,
  output reg  [5:0] o_wake
);
  // Idle pins, mains absent at start
  initial begin
    o_pwr_sw = 1'b0;
    o_ac_ok = 1'b0;
    o_wake = 6'h00;
  end
  // Press held n cycles, then settle past debounce; returns just after an edge
  task press(input int n);
    @(posedge i_core_clk) #1 o_pwr_sw = 1'b1;
    repeat (n) @(posedge i_core_clk);
    #1 o_pwr_sw = 1'b0;
    repeat (DEB_CYC + 8) @(posedge i_core_clk);
    #1;
  endtask
  // Wake lines in mask m active for a few cycles
  task wake(input logic [5:0] m);
    @(posedge i_core_clk) #1 o_wake = m;
    repeat (6) @(posedge i_core_clk);
    #1 o_wake = 6'h00;
    repeat (8) @(posedge i_core_clk);
    #1;
  endtask
  // Mains level, given time to pass the synchroniser
  task mains(input logic v);
    @(posedge i_core_clk) #1 o_ac_ok = v;
    repeat (10) @(posedge i_core_clk);
    #1;
  endtask
endmodule // pbs_far_side

//--- pbs_seq_props.sv
// Port checker for the power state sequencer.
// Assumes it is bound onto pbs_sequencer.
`timescale 1ns/10ps
`include "pbs_consts.vh"
module pbs_seq_props #(
  parameter DEB_CYC  = 4,
  parameter LONG_CYC = 40
) (
  input wire       i_core_clk,
  input wire       i_rst,
  input wire       i_ac_ok,
  input wire       i_os_sleep_s1,
  input wire       i_os_soft_off,
  input wire       o_main_rails_on,
  input wire       o_cpu_stop_grant,
  input wire       o_cold_boot,
  input wire       o_wake_event,
  input wire [2:0] o_sys_state
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  wire [2:0] st = o_sys_state;
  // Settled sleep and off states
  sequence s_in_s1;
    ##[1:2] (st == `PBS_ST_S1 && o_cpu_stop_grant);
  endsequence
  sequence s_off;
    ##[1:2] (st == `PBS_ST_S5 && !o_main_rails_on);
  endsequence
  property p_rails; o_main_rails_on == (st <= `PBS_ST_S1); endproperty
  property p_grant; o_cpu_stop_grant == (st == `PBS_ST_S1); endproperty
  property p_os_s1;
    st == `PBS_ST_S0 && i_os_sleep_s1 && !i_os_soft_off && i_ac_ok |-> s_in_s1;
  endproperty
  property p_soft; st == `PBS_ST_S0 && i_os_soft_off && i_ac_ok |-> s_off; endproperty
  property p_mains; $fell(i_ac_ok) |-> ##[1:8] st == `PBS_ST_S5; endproperty
  property p_wake; o_wake_event |-> ##[0:1] st == `PBS_ST_S0; endproperty
  property p_wpulse; o_wake_event |=> !o_wake_event; endproperty
  property p_cpulse; o_cold_boot |=> !o_cold_boot; endproperty
  property p_s5_exit;
    st == `PBS_ST_S5 |=> st == `PBS_ST_S5 || st == `PBS_ST_S0;
  endproperty
  property p_s3_exit; st == `PBS_ST_S3 |=> st != `PBS_ST_S1; endproperty
  a_rails: assert property (p_rails) else $error("rails wrong for state");
  a_grant: assert property (p_grant) else $error("stop grant wrong");
  a_os_s1: assert property (p_os_s1) else $error("no sleep entry");
  a_soft: assert property (p_soft) else $error("soft off failed");
  a_mains: assert property (p_mains) else $error("mains loss not off");
  a_wake: assert property (p_wake) else $error("wake without S0");
  a_wpulse: assert property (p_wpulse) else $error("wake pulse long");
  a_cpulse: assert property (p_cpulse) else $error("cold pulse long");
  a_s5_exit: assert property (p_s5_exit) else $error("bad S5 exit");
  a_s3_exit: assert property (p_s3_exit) else $error("bad S3 exit");
endmodule // pbs_seq_props

bind pbs_sequencer pbs_seq_props #(
  .DEB_CYC(DEB_CYC),
  .LONG_CYC(LONG_CYC)
) u_props (
  .i_core_clk(i_core_clk),
  .i_rst(i_rst),
  .i_ac_ok(i_ac_ok),
  .i_os_sleep_s1(i_os_sleep_s1),
  .i_os_soft_off(i_os_soft_off),
  .o_main_rails_on(o_main_rails_on),
  .o_cpu_stop_grant(o_cpu_stop_grant),
  .o_cold_boot(o_cold_boot),
  .o_wake_event(o_wake_event),
  .o_sys_state(o_sys_state)
);

//--- pbs_sequencer.v
// Power state sequencer: S0, S1, S3, S4, S5 tracking, wake, supply control.
// Assumes standby clock and reset; pins arrive asynchronous and are synchronised.
// Notes on behaviour
// RULE1 - A short press in soft-off moves the system to working.
// RULE2 - A short press while working enters the configured sleep state, S1 or S3.
// RULE3 - A long press while working forces a fail-safe power-off to soft-off.
// RULE4 - A short press while sleeping in S1 or S3 wakes the system to working.
// RULE5 - A long press while sleeping in S1 or S3 powers the system off instead.
// RULE6 - Power switch and RTC alarm wake the system from S1, S3, S4 and S5.
// RULE7 - Modem, PS/2 and USB wakes count only from S1 and S3.
// RULE8 - LAN and PME wake from S1, S3, S4, and from S5 only when enabled, default off.
// RULE9 - The software power-off command drops all main rails but keeps standby.
// RULE10 - After mains returns the prior on or off state is restored by default, selectable.
// RULE11 - In S3, S4, S5 only wake logic is powered and leaving S5 is a cold boot.
// RULE12 - In S1 the processor is held in stop grant with context retained.
// RULE13 - The switch is debounced and timed, and exactly four seconds is a long press.
`timescale 1ns/10ps
`include "pbs_consts.vh"
module pbs_sequencer #(
  parameter DEB_CYC  = `PBS_DEB_CYC,
  parameter LONG_CYC = `PBS_LONG_CYC
) (
  // Clock and reset
  input  wire       i_core_clk,
  input  wire       i_rst,
  // Front panel and wake pins, asynchronous
  input  wire       i_pwr_sw,
  input  wire       i_rtc_alarm,
  input  wire       i_lan_wake,
  input  wire       i_pme_n,
  input  wire       i_modem_ri,
  input  wire       i_ps2_act,
  input  wire       i_usb_act,
  input  wire       i_ac_ok,
  // Operating system commands, same clock, one-cycle pulses
  input  wire       i_os_sleep_s1,
  input  wire       i_os_sleep_s3,
  input  wire       i_os_sleep_s4,
  input  wire       i_os_soft_off,
  // Configuration levels, same clock
  input  wire       i_cfg_btn_s3,
  input  wire       i_cfg_s5_lan_wake,
  input  wire [1:0] i_cfg_after_fail,
  // Supply and processor control
  output reg        o_main_rails_on,
  output reg        o_cpu_stop_grant,
  output reg        o_cold_boot,
  output reg        o_wake_event,
  output reg  [2:0] o_sys_state
);
  // Sleep state codes for the state machine
  localparam [2:0] ST_S0 = `PBS_ST_S0;
  localparam [2:0] ST_S1 = `PBS_ST_S1;
  localparam [2:0] ST_S3 = `PBS_ST_S3;
  localparam [2:0] ST_S4 = `PBS_ST_S4;
  localparam [2:0] ST_S5 = `PBS_ST_S5;

  reg [7:0]  sync1_q;
  reg [7:0]  sync2_q;
  reg [7:0]  prev_q;
  reg [2:0]  state_q;
  reg [2:0]  state_d;
  reg        last_on_q;
  reg        cold_d;
  wire       short_press;
  wire       long_press;
  wire       sw_sync;
  wire       rtc_rise;
  wire       lan_rise;
  wire       pme_rise;
  wire       modem_rise;
  wire       ps2_rise;
  wire       usb_rise;
  wire       ac_ok;
  wire       ac_rise;
  wire       wake_any;
  wire       wake_ls;

  // Light sleep states keep context and accept every wake source
  function is_light;
    input [2:0] s;
    begin
      is_light = (s == ST_S1) || (s == ST_S3);
    end
  endfunction

  // Rising edge of a synchronised level against its previous sample
  function rise_of;
    input now_v;
    input old_v;
    begin
      rise_of = now_v & ~old_v;
    end
  endfunction

  // Two-stage synchronisers; PME is active low so inverted first
  // History resets low; a mains rise after reset applies the restore policy
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
      prev_q  <= 8'h00;
    end else begin
      sync1_q <= {i_ac_ok, i_usb_act, i_ps2_act, i_modem_ri, ~i_pme_n,
                  i_lan_wake, i_rtc_alarm, i_pwr_sw};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign sw_sync    = sync2_q[0];
  assign rtc_rise   = rise_of(sync2_q[1], prev_q[1]);
  assign lan_rise   = rise_of(sync2_q[2], prev_q[2]);
  assign pme_rise   = rise_of(sync2_q[3], prev_q[3]);
  assign modem_rise = rise_of(sync2_q[4], prev_q[4]);
  assign ps2_rise   = rise_of(sync2_q[5], prev_q[5]);
  assign usb_rise   = rise_of(sync2_q[6], prev_q[6]);
  assign ac_ok      = sync2_q[7];
  assign ac_rise    = rise_of(sync2_q[7], prev_q[7]);

  // RULE13 switch timing in its own module
  pbs_button_timer #(
    .DEB_CYC  (DEB_CYC),
    .LONG_CYC (LONG_CYC)
  ) u_btn (
    .i_core_clk    (i_core_clk),
    .i_rst         (i_rst),
    .i_sw_sync     (sw_sync),
    .o_short_press (short_press),
    .o_long_press  (long_press)
  );

  // RULE7 low-power-only wakes
  assign wake_ls  = modem_rise | ps2_rise | usb_rise;
  // Wake qualified by the current sleeping state
  assign wake_any =
    // RULE6 switch and alarm
    ((state_q != ST_S0) & (short_press | rtc_rise)) |
    (is_light(state_q) & wake_ls) |
    // RULE8 network and PME, S5 gated by enable
    ((is_light(state_q) || state_q == ST_S4) & (lan_rise | pme_rise)) |
    ((state_q == ST_S5) & i_cfg_s5_lan_wake & (lan_rise | pme_rise));

  // Next-state logic; mains loss drops everything into S5
  always @* begin
    state_d = state_q;
    cold_d  = 1'b0;
    if (!ac_ok) begin
      state_d = `PBS_ST_S5;
    end else if (ac_rise) begin
      // RULE10 restore per after-failure setting
      if (i_cfg_after_fail == `PBS_AFL_ON ||
          (i_cfg_after_fail == `PBS_AFL_LAST && last_on_q)) begin
        state_d = `PBS_ST_S0;
        cold_d  = 1'b1;
      end else begin
        state_d = `PBS_ST_S5;
      end
    end else begin
      case (state_q)
        `PBS_ST_S0: begin
          if (long_press) begin
            // RULE3 fail-safe off
            state_d = `PBS_ST_S5;
          end else if (i_os_soft_off) begin
            // RULE9 software off
            state_d = `PBS_ST_S5;
          end else if (short_press) begin
            // RULE2 configured sleep
            state_d = i_cfg_btn_s3 ? `PBS_ST_S3 : `PBS_ST_S1;
          end else if (i_os_sleep_s1) begin
            state_d = `PBS_ST_S1;
          end else if (i_os_sleep_s3) begin
            state_d = `PBS_ST_S3;
          end else if (i_os_sleep_s4) begin
            state_d = `PBS_ST_S4;
          end
        end
        `PBS_ST_S1, `PBS_ST_S3: begin
          if (long_press) begin
            // RULE5 long press powers off
            state_d = `PBS_ST_S5;
          end else if (wake_any) begin
            // RULE4 wake to working
            state_d = `PBS_ST_S0;
          end
        end
        `PBS_ST_S4, `PBS_ST_S5: begin
          if (wake_any) begin
            // RULE1 power-on; RULE11 no context, cold boot
            state_d = `PBS_ST_S0;
            cold_d  = 1'b1;
          end
        end
        default: begin
          state_d = `PBS_ST_S5;
        end
      endcase
    end
  end

  // State and remembered on/off, last kept across mains loss
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      state_q   <= `PBS_ST_S5;
      last_on_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      // Frozen while mains is low so the forced S5 cannot overwrite it
      if (ac_ok && !ac_rise) begin
        last_on_q <= (state_q != `PBS_ST_S5);
      end
    end
  end

  // Registered outputs
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_main_rails_on  <= 1'b0;
      o_cpu_stop_grant <= 1'b0;
      o_cold_boot      <= 1'b0;
      o_wake_event     <= 1'b0;
      o_sys_state      <= `PBS_ST_S5;
    end else begin
      // RULE9 RULE11 main rails only in S0 and S1, standby untouched
      o_main_rails_on  <= (state_d == `PBS_ST_S0) || (state_d == `PBS_ST_S1);
      // RULE12 stop grant while in S1
      o_cpu_stop_grant <= (state_d == `PBS_ST_S1);
      o_cold_boot      <= cold_d;
      o_wake_event     <= (state_q != `PBS_ST_S0) && (state_d == `PBS_ST_S0);
      o_sys_state      <= state_d;
    end
  end
endmodule // pbs_sequencer

//--- testbench.sv
// Self-checking bench for the power state sequencer.
// Assumes short debounce and long-press counts.
`timescale 1ns/10ps
`include "pbs_consts.vh"
module testbench;
  localparam int DEB = 4;
  localparam int LNG = 40;
  logic clk, rst, cfg_s3, cfg_lan, sw, ac;
  logic [3:0] os;
  logic [1:0] cfg_af;
  logic [5:0] wk;
  logic rails, sg, cb, we;
  logic [2:0] st;
  int failures = 0;
  int num_checks = 0;
  int cyc = 0;
  int cb_n = 0;
  int we_n = 0;
  pbs_far_side #(.DEB_CYC(DEB)) u_far (
    .i_core_clk(clk),
    .o_pwr_sw(sw),
    .o_ac_ok(ac),
    .o_wake(wk)
  );
  pbs_sequencer #(.DEB_CYC(DEB), .LONG_CYC(LNG)) i_pbs_sequencer (
    .i_core_clk(clk),
    .i_rst(rst),
    .i_pwr_sw(sw),
    .i_rtc_alarm(wk[0]),
    .i_lan_wake(wk[1]),
    .i_pme_n(~wk[5]),
    .i_modem_ri(wk[2]),
    .i_ps2_act(wk[3]),
    .i_usb_act(wk[4]),
    .i_ac_ok(ac),
    .i_os_sleep_s1(os[0]),
    .i_os_sleep_s3(os[1]),
    .i_os_sleep_s4(os[2]),
    .i_os_soft_off(os[3]),
    .i_cfg_btn_s3(cfg_s3),
    .i_cfg_s5_lan_wake(cfg_lan),
    .i_cfg_after_fail(cfg_af),
    .o_main_rails_on(rails),
    .o_cpu_stop_grant(sg),
    .o_cold_boot(cb),
    .o_wake_event(we),
    .o_sys_state(st)
  );
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Hang guard, far above the expected run; also counts output pulses
  always @(posedge clk) begin
    cyc++;
    if (cb === 1'b1) cb_n++;
    if (we === 1'b1) we_n++;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  task tally_and_finish;
    if (failures == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [2:0] s, input logic [2:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask
  // Bounded wait on the state output
  // Sampled just after the edge, once the outputs have settled
  task ws(input logic [2:0] e);
    for (int i = 0; i < 300 && st !== e; i++) begin
      @(posedge clk);
      #1;
    end
  endtask
  task os_cmd(input logic [3:0] m);
    @(posedge clk) #1 os = m;
    @(posedge clk) #1 os = 4'h0;
  endtask
  task t_button;
    u_far.press(12);
    ws(`PBS_ST_S0);
    chk("s5 short", st, `PBS_ST_S0);
    u_far.press(12);
    ws(`PBS_ST_S1);
    chk("grant", {2'h0, sg}, 3'h1);
    chk("s5 cold", cb_n[2:0], 3'h1);
    chk("s5 wake", we_n[2:0], 3'h1);
    u_far.press(12);
    ws(`PBS_ST_S0);
    chk("s1 short", st, `PBS_ST_S0);
    #1 cfg_s3 = 1'b1;
    u_far.press(12);
    ws(`PBS_ST_S3);
    chk("s3 rails", {2'h0, rails}, 3'h0);
    chk("s1 warm", cb_n[2:0], 3'h1);
    chk("s1 wake", we_n[2:0], 3'h2);
    u_far.press(LNG + DEB + 10);
    ws(`PBS_ST_S5);
    chk("sleep long", st, `PBS_ST_S5);
    u_far.press(12);
    ws(`PBS_ST_S0);
    u_far.press(LNG + DEB + 10);
    ws(`PBS_ST_S5);
    chk("s0 long", st, `PBS_ST_S5);
    u_far.press(LNG - 1);
    ws(`PBS_ST_S0);
    chk("edge short", st, `PBS_ST_S0);
    u_far.press(LNG);
    ws(`PBS_ST_S5);
    chk("edge long", st, `PBS_ST_S5);
  endtask
  task t_wake;
    for (int k = 1; k < 6; k++) u_far.wake(6'h01 << k);
    chk("s5 ignore", st, `PBS_ST_S5);
    u_far.wake(6'h01);
    ws(`PBS_ST_S0);
    chk("rtc", st, `PBS_ST_S0);
    os_cmd(4'h1);
    ws(`PBS_ST_S1);
    chk("os s1", {2'h0, sg}, 3'h1);
    u_far.wake(6'h08);
    ws(`PBS_ST_S0);
    chk("s1 ps2", st, `PBS_ST_S0);
    os_cmd(4'h2);
    ws(`PBS_ST_S3);
    chk("os s3", st, `PBS_ST_S3);
    u_far.wake(6'h04);
    ws(`PBS_ST_S0);
    chk("s3 modem", st, `PBS_ST_S0);
    os_cmd(4'h4);
    u_far.wake(6'h10);
    chk("s4 usb", st, `PBS_ST_S4);
    u_far.wake(6'h20);
    ws(`PBS_ST_S0);
    chk("s4 pme", st, `PBS_ST_S0);
    os_cmd(4'h8);
    ws(`PBS_ST_S5);
    chk("soft off", {2'h0, rails}, 3'h0);
    #1 cfg_lan = 1'b1;
    u_far.wake(6'h02);
    ws(`PBS_ST_S0);
    chk("s5 lan", st, `PBS_ST_S0);
  endtask
  task t_mains;
    int c0;
    int w0;
    #1 cfg_af = `PBS_AFL_LAST;
    u_far.mains(1'b0);
    ws(`PBS_ST_S5);
    c0 = cb_n;
    w0 = we_n;
    u_far.mains(1'b1);
    ws(`PBS_ST_S0);
    chk("restore", st, `PBS_ST_S0);
    os_cmd(4'h8);
    chk("restore cold", 3'(cb_n - c0), 3'h1);
    chk("restore wake", 3'(we_n - w0), 3'h1);
    ws(`PBS_ST_S5);
    #1 cfg_af = `PBS_AFL_ON;
    u_far.mains(1'b0);
    u_far.mains(1'b1);
    ws(`PBS_ST_S0);
    chk("power on", st, `PBS_ST_S0);
    os_cmd(4'h8);
    ws(`PBS_ST_S5);
    #1 cfg_af = `PBS_AFL_LAST;
    u_far.mains(1'b0);
    u_far.mains(1'b1);
    chk("restore off", st, `PBS_ST_S5);
  endtask
  // Reset, mains up with stay-off policy, then scenarios
  initial begin
    rst = 1'b1;
    os = 4'h0;
    cfg_s3 = 1'b0;
    cfg_lan = 1'b0;
    cfg_af = `PBS_AFL_OFF;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    u_far.mains(1'b1);
    chk("stay off", st, `PBS_ST_S5);
    t_button();
    t_wake();
    t_mains();
    tally_and_finish();
  end
endmodule // testbench
